// *** common/sram_port_pkg.sv ***
// shared constants for the pipelined burst sram port
// assumes: one rising-edge clock, controller logic on that same clock
package sram_port_pkg;

    // =========================================================
    // organisations
    localparam int WIDE_DATA_W   = 36;  // 256k x 36
    localparam int WIDE_ADDR_W   = 18;
    localparam int WIDE_LANES    = 4;
    localparam int NARROW_DATA_W = 18;  // 512k x 18
    localparam int NARROW_ADDR_W = 19;
    localparam int NARROW_LANES  = 2;

    // =========================================================
    // burst and pipeline
    localparam int BURST_W        = 2;  // low address bits that wrap
    localparam int CMD_FIFO_DEPTH = 4;  // pending write commands
    localparam int READ_LATENCY   = 2;  // enabled edges, address to data

    // =========================================================
    // reset values
    localparam logic [BURST_W-1:0] BURST_CNT_RESET = 2'h0;
    localparam logic               FLAG_RESET      = 1'b0;

    // burst order, as given by the order strap
    typedef enum logic [0:0] {
        BURST_INTERLEAVED = 1'b0,
        BURST_LINEAR      = 1'b1
    } burst_order_type;

endpackage : sram_port_pkg

// *** rtl/sram_cmd_fifo.sv ***
// small fifo carrying write commands until their data arrives
// assumes: depth is a power of two, single clock, synchronous reset copy
`timescale 1ns/1ps
module sram_cmd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];  // entries
    logic [PW:0]      wr_ptr_q;         // extra bit tells full from empty
    logic [PW:0]      rd_ptr_q;
    logic             push;
    logic             pop;

    // =========================================================
    // flags
    assign in_ready  = (wr_ptr_q[PW] == rd_ptr_q[PW]) ||
                       (wr_ptr_q[PW-1:0] != rd_ptr_q[PW-1:0]);
    assign out_valid = (wr_ptr_q != rd_ptr_q);
    assign out_data  = store_q[rd_ptr_q[PW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    // storage, data only, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            store_q[wr_ptr_q[PW-1:0]] <= in_data;
        end
    end

endmodule : sram_cmd_fifo

// *** rtl/sram_core_mem.sv ***
// byte-lane writable memory array with registered read data
// assumes: read and write strobes are already qualified by the caller
`timescale 1ns/1ps
module sram_core_mem #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 36,
    parameter int LANES  = 4
) (
    // clock
    input  wire logic              clk,
    // write port
    input  wire logic              we,
    input  wire logic [LANES-1:0]  wlane,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    // read port
    input  wire logic              re,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);
    localparam int LW = DATA_W / LANES;  // bits per byte lane

    logic [DATA_W-1:0] array_q [2**ADDR_W];

    // =========================================================
    // all lanes in one process, the write finishes inside the edge
    always_ff @(posedge clk) begin
        for (int g = 0; g < LANES; g++) begin
            if (we && wlane[g]) begin
                array_q[waddr][g*LW +: LW] <= wdata[g*LW +: LW];
            end
        end
    end

    // read data held until the next read
    always_ff @(posedge clk) begin
        if (re) begin
            rdata <= array_q[raddr];
        end
    end

endmodule : sram_core_mem

// *** rtl/sram_port.sv ***
// pipelined burst sram port: input registers, array, output registers
// assumes: controller runs on core_clk; oe pin acts without the clock
//
// Overview of operation
// - all synchronous inputs registered on rising edge
// - read data leaves through output registers
// - qualifier high freezes the whole pipeline
// - back to back reads and writes, no waits
// - write strobe plus per-lane byte write selects
// - writes self-timed inside one clock edge
// - three chip selects decide device selection
// - output enable gates drivers without clock
// - drivers off during write data phase
// - burst advances low bits, linear or interleaved
// - sleep input stops cycles, clock may stop
// - 256k x 36 or 512k x 18 organisation
`timescale 1ns/1ps
module sram_port #(
    parameter bit WIDE = 1'b1,  // organisation select
    localparam int DATA_W = WIDE ? sram_port_pkg::WIDE_DATA_W
                                 : sram_port_pkg::NARROW_DATA_W,
    localparam int ADDR_W = WIDE ? sram_port_pkg::WIDE_ADDR_W
                                 : sram_port_pkg::NARROW_ADDR_W,
    localparam int LANES  = WIDE ? sram_port_pkg::WIDE_LANES
                                 : sram_port_pkg::NARROW_LANES
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // command
    input  wire logic              clock_qualifier_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              burst_advance,
    input  wire logic              write_n,
    input  wire logic              byte_lane0_write_n,
    input  wire logic              byte_lane1_write_n,
    input  wire logic              byte_lane2_write_n,
    input  wire logic              byte_lane3_write_n,
    // selection
    input  wire logic              chip_select_low_first,
    input  wire logic              chip_select_high,
    input  wire logic              chip_select_low_second,
    input  wire logic              output_enable_n,
    // static modes
    input  wire logic              burst_order_linear,
    input  wire logic              sleep_request,
    // data pins, split in three
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe
);
    localparam int BW   = sram_port_pkg::BURST_W;
    localparam int CMDW = ADDR_W + LANES;

    // =========================================================
    // reset release and pin synchronisers
    logic rst_meta_q;    // first stage, read only by rst_n_q
    logic rst_n_q;       // reset used by the design
    logic order_meta_q;  // order strap, first stage
    logic order_q;       // synchronised burst order
    logic sleep_meta_q;  // sleep pin, first stage
    logic sleep_q;       // synchronised sleep

    // reset leaves through two flops so release is clean
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // quasi-static pins may move at any time, so two flops each
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            order_meta_q <= sram_port_pkg::FLAG_RESET;
            order_q      <= sram_port_pkg::FLAG_RESET;
            sleep_meta_q <= sram_port_pkg::FLAG_RESET;
            sleep_q      <= sram_port_pkg::FLAG_RESET;
        end else begin
            order_meta_q <= burst_order_linear;
            order_q      <= order_meta_q;
            sleep_meta_q <= sleep_request;
            sleep_q      <= sleep_meta_q;
        end
    end

    // =========================================================
    // edge qualification and decode
    logic             en;         // this edge counts
    logic             sel;        // device selected
    logic [LANES-1:0] lanes;      // active-high lane write mask
    logic [3:0]       lanes_all;  // all four lane pins

    assign en  = ~clock_qualifier_n;
    assign sel = ~chip_select_low_first & chip_select_high &
                 ~chip_select_low_second;
    assign lanes_all = ~{byte_lane3_write_n, byte_lane2_write_n,
                         byte_lane1_write_n, byte_lane0_write_n};
    assign lanes = lanes_all[LANES-1:0];

    // next low address bits of a burst
    function automatic logic [BW-1:0] burst_low(
        input logic [BW-1:0] start,
        input logic [BW-1:0] step,
        input logic          linear
    );
        logic [BW-1:0] r;
        r = linear ? start + step : start ^ step;
        return r;
    endfunction : burst_low

    // =========================================================
    // burst tracking
    logic [ADDR_W-1:0] base_q;     // address that opened the burst
    logic [BW-1:0]     cnt_q;      // beats since the start
    logic              live_q;     // burst may continue
    logic              burst_wr_q; // burst direction
    logic [BW-1:0]     cnt_d;

    assign cnt_d = cnt_q + 1'b1;

    // load opens a burst, advance steps it, sleep ends it
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            base_q     <= '0;
            cnt_q      <= sram_port_pkg::BURST_CNT_RESET;
            live_q     <= sram_port_pkg::FLAG_RESET;
            burst_wr_q <= sram_port_pkg::FLAG_RESET;
        end else if (en) begin
            if (sleep_q) begin
                live_q <= 1'b0;
            end else if (burst_advance) begin
                cnt_q <= cnt_d;
            end else begin
                base_q     <= addr;
                cnt_q      <= sram_port_pkg::BURST_CNT_RESET;
                live_q     <= sel;
                burst_wr_q <= ~write_n;
            end
        end
    end

    // =========================================================
    // input registers, stage one
    logic              s1_valid_q;  // selected cycle held
    logic              s1_wr_q;     // it is a write
    logic [ADDR_W-1:0] s1_addr_q;   // its address
    logic [LANES-1:0]  s1_lanes_q;  // its byte lanes
    logic [ADDR_W-1:0] adv_addr;    // address of the next beat

    assign adv_addr = {base_q[ADDR_W-1:BW],
                       burst_low(base_q[BW-1:0], cnt_d, order_q)};

    // every command pin the controller drives is taken on the same edge
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s1_valid_q <= sram_port_pkg::FLAG_RESET;
            s1_wr_q    <= sram_port_pkg::FLAG_RESET;
            s1_addr_q  <= '0;
            s1_lanes_q <= '0;
        end else if (en) begin
            s1_lanes_q <= lanes;
            if (sleep_q) begin
                s1_valid_q <= 1'b0;
            end else if (burst_advance) begin
                s1_valid_q <= live_q;
                s1_wr_q    <= burst_wr_q;
                s1_addr_q  <= adv_addr;
            end else begin
                s1_valid_q <= sel;
                s1_wr_q    <= ~write_n;
                s1_addr_q  <= addr;
            end
        end
    end

    // =========================================================
    // stage two: array read issued, write command queued
    logic s2_rd_q;  // array read data belongs to a read
    logic s2_wr_q;  // write data due at the next enabled edge
    logic rd_go;    // array read this edge

    assign rd_go = en & s1_valid_q & ~s1_wr_q;

    // any order of reads and writes passes, one per edge
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s2_rd_q <= sram_port_pkg::FLAG_RESET;
            s2_wr_q <= sram_port_pkg::FLAG_RESET;
        end else if (en) begin
            s2_rd_q <= s1_valid_q & ~s1_wr_q;
            s2_wr_q <= s1_valid_q & s1_wr_q;
        end
    end

    // =========================================================
    // write command queue
    // the array write happens one edge after the data is taken,
    // so commands wait here; depth four covers the pipeline
    logic            push_valid;
    logic            push_ready;
    logic            pop_valid;
    logic            pop_ready;
    logic [CMDW-1:0] pop_cmd;

    assign push_valid = en & s1_valid_q & s1_wr_q & push_ready;

    sram_cmd_fifo #(
        .WIDTH (CMDW),
        .DEPTH (sram_port_pkg::CMD_FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk       (core_clk),
        .rst_n     (rst_n_q),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   ({s1_addr_q, s1_lanes_q}),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_cmd)
    );

    // =========================================================
    // stage three: output register and write data register
    logic              drive_q;   // output stage holds read data
    logic              wr3_q;     // write data register is live
    logic [DATA_W-1:0] wdata_q;   // captured write data
    logic [DATA_W-1:0] dq_out_q;  // output data register
    logic [DATA_W-1:0] rdata;     // array read data

    // drivers turn off on the clock when the stage holds a write
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            drive_q <= sram_port_pkg::FLAG_RESET;
            wr3_q   <= sram_port_pkg::FLAG_RESET;
        end else if (en) begin
            drive_q <= s2_rd_q;
            wr3_q   <= s2_wr_q;
        end
    end

    // data registers, two enabled edges behind the command
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wdata_q  <= '0;
            dq_out_q <= '0;
        end else if (en) begin
            wdata_q <= dq_in;
            if (s2_rd_q) begin
                dq_out_q <= rdata;
            end
        end
    end

    // =========================================================
    // array; write strobes come only from the clock edge
    assign pop_ready = en & wr3_q;

    sram_core_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .LANES  (LANES)
    ) u_mem (
        .clk   (core_clk),
        .we    (pop_valid & pop_ready),
        .wlane (pop_cmd[LANES-1:0]),
        .waddr (pop_cmd[CMDW-1:LANES]),
        .wdata (wdata_q),
        .re    (rd_go),
        .raddr (s1_addr_q),
        .rdata (rdata)
    );

    // =========================================================
    // pins; oe is the one path that bypasses the clock
    assign dq_out = dq_out_q;
    assign dq_oe  = drive_q & ~output_enable_n;

    // =========================================================
    // checks
    input_capture_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        en && !sleep_q && !burst_advance |=> s1_addr_q == $past(addr))
        else $error("address not captured on enabled edge");

    stall_freeze_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        !en |=> $stable(s1_addr_q) && $stable(drive_q)
                && $stable(dq_out_q) && $stable(cnt_q))
        else $error("pipeline moved on a qualified-off edge");

    read_latency_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        (en && s1_valid_q && !s1_wr_q) ##1 en[*2] |-> drive_q)
        else $error("read data not driven two edges after capture");

    read_output_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        en && s2_rd_q |=> dq_out_q == $past(rdata))
        else $error("output register missed array data");

    no_wait_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        en && s1_valid_q && s1_wr_q |-> push_ready)
        else $error("write command queue refused a write");

    write_strobe_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        en && wr3_q |-> pop_valid)
        else $error("write data without its command");

    chip_select_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        en && !burst_advance && !sel |=> !s1_valid_q)
        else $error("deselected cycle accepted");

    oe_gate_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        output_enable_n |-> !dq_oe)
        else $error("drivers on with output enable off");

    write_tristate_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        en && s2_wr_q
        |=> !drive_q && !dq_oe)
        else $error("drivers on during write data phase");

    burst_step_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        en && !sleep_q && burst_advance && live_q
        |=> s1_valid_q && s1_addr_q[BW-1:0] ==
            (order_q ? base_q[BW-1:0] + cnt_q : base_q[BW-1:0] ^ cnt_q))
        else $error("burst beat address wrong");

    sleep_idle_a: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        en && sleep_q |=> !s1_valid_q ##1 (!$past(en) || !s2_rd_q))
        else $error("cycle accepted while asleep");

endmodule : sram_port

// *** tb/sram_ctrl_model.sv ***
// controller model facing the sram port: command pins and write data
// assumes: one core_clk, commands set by issue() just after a rising edge
`timescale 1ns/1ps
module sram_ctrl_model (
    // clock
    input  wire logic        core_clk,
    // command pins
    output logic             clock_qualifier_n,
    output logic [17:0]      addr,
    output logic             burst_advance,
    output logic             write_n,
    output logic [3:0]       lanes_n,
    output logic [2:0]       sel,        // low_first, high, low_second
    // data pins
    output logic [35:0]      dq_in,
    input  wire logic [35:0] dq_out,
    input  wire logic        dq_oe
);
    // =========================================================
    // pipeline of taken commands, kind 0 none, 1 read, 2 write
    logic [1:0]  kind_now;               // kind asked for on the pins
    logic [35:0] data_now;               // write word for that command
    logic [1:0]  k1, k2, k3;             // kinds one, two, three edges old
    logic [35:0] d1;                     // word of the newest command
    logic [1:0]  q_kind [$];             // finished beats for the bench
    logic [35:0] q_data [$];
    logic        q_oe   [$];

    initial begin
        clock_qualifier_n = 1'b0;
        {addr, burst_advance, write_n, lanes_n, sel} = '0;
        {kind_now, data_now, k1, k2, k3, d1, dq_in} = '0;
    end

    // advance only on enabled edges, like the device
    always @(posedge core_clk) begin
        if (!clock_qualifier_n) begin
            // word two enabled edges after its command
            if (k1 == 2'h2) dq_in <= d1;
            else dq_in <= ~dq_in;        // released: never the last value
            if (k3 != 2'h0) begin
                q_kind.push_back(k3);
                q_data.push_back(dq_out);
                q_oe.push_back(dq_oe);
            end
            k1 <= kind_now;
            d1 <= data_now;
            k2 <= k1;
            k3 <= k2;
        end
    end

    // one command per edge, any mix, strobe and lanes together
    task automatic issue(input logic [1:0] kind, input logic wr_n, input logic [2:0] s,
                         input logic [3:0] ln, input logic adv, input logic [17:0] a,
                         input logic [35:0] d);
        @(posedge core_clk);
        kind_now      <= kind;
        data_now      <= d;
        write_n       <= wr_n;
        sel           <= s;
        lanes_n       <= ln;
        burst_advance <= adv;
        addr          <= a;
    endtask : issue

    // stretch the cycle: qualifier high, pins left deselected
    task automatic hold_on();
        @(posedge core_clk);
        clock_qualifier_n <= 1'b1;
        kind_now          <= 2'h0;
        sel               <= 3'h0;
    endtask : hold_on

    task automatic hold_off();
        @(posedge core_clk);
        clock_qualifier_n <= 1'b0;
    endtask : hold_off
endmodule : sram_ctrl_model

// *** tb/pipelined_burst_sram_port_tb.sv ***
// testbench of the sram port, wide organisation
// assumes: controller model drives the command pins, bench the static ones
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb;
    // =========================================================
    // signals
    logic        core_clk, nrst, output_enable_n, burst_order_linear, sleep_request;
    logic        clock_qualifier_n, burst_advance, write_n, dq_oe;
    logic [17:0] addr;
    logic [3:0]  lanes_n;
    logic [2:0]  sel;
    logic [35:0] dq_in, dq_out;
    int          n_fail, checks_done, cycles;

    sram_port #(.WIDE(1'b1)) u_sram_port (.core_clk, .nrst, .clock_qualifier_n, .addr,
        .burst_advance, .write_n, .byte_lane0_write_n(lanes_n[0]),
        .byte_lane1_write_n(lanes_n[1]), .byte_lane2_write_n(lanes_n[2]),
        .byte_lane3_write_n(lanes_n[3]), .chip_select_low_first(sel[2]),
        .chip_select_high(sel[1]), .chip_select_low_second(sel[0]), .output_enable_n,
        .burst_order_linear, .sleep_request, .dq_in, .dq_out, .dq_oe);
    sram_ctrl_model u_sram_ctrl_model (.core_clk, .clock_qualifier_n, .addr, .burst_advance,
        .write_n, .lanes_n, .sel, .dq_in, .dq_out, .dq_oe);

    // =========================================================
    // clock and hang guard, far above the run's length
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            end_of_test();
        end
    end

    // =========================================================
    // shared helpers
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [17:0] a, input logic [35:0] d, input logic [3:0] ln);
        u_sram_ctrl_model.issue(2'h2, 1'b0, 3'h2, ln, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [17:0] a);
        u_sram_ctrl_model.issue(2'h1, 1'b1, 3'h2, 4'hF, 1'b0, a, 36'h0);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) u_sram_ctrl_model.issue(2'h0, 1'b1, 3'h0, 4'hF, 1'b0, 18'h0, 36'h0);
    endtask : idle

    // oldest finished beat: reads carry data and drive, writes leave dq alone
    task automatic expect_beat(input logic [1:0] kind, input logic [35:0] exp);
        int i;
        for (i = 0; i < 40 && u_sram_ctrl_model.q_kind.size() == 0; i++) @(posedge core_clk);
        check(36'(u_sram_ctrl_model.q_kind.size() != 0), 36'h1);
        if (u_sram_ctrl_model.q_kind.size() == 0) return;
        check(36'(u_sram_ctrl_model.q_kind.pop_front()), 36'(kind));
        if (kind == 2'h1) check(u_sram_ctrl_model.q_data.pop_front(), exp);
        else void'(u_sram_ctrl_model.q_data.pop_front());
        check(36'(u_sram_ctrl_model.q_oe.pop_front()), 36'(kind == 2'h1));
    endtask : expect_beat

    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                          input logic [3:0] ln);
        for (int i = 0; i < 4; i++) if (!ln[i]) o[9*i +: 9] = n[9*i +: 9];
        return o;
    endfunction : merge

    // =========================================================
    // scenarios
    task automatic t_lanes();
        wr(18'h13, 36'h123456789, 4'h0);
        wr(18'h13, 36'hABCDEF012, 4'hD);
        wr(18'h13, 36'h0FFFFFFFF, 4'hF);
        idle(3);
        rd(18'h13);
        idle(3);
        repeat (3) expect_beat(2'h2, 36'h0);
        expect_beat(2'h1, merge(merge(36'h123456789, 36'hABCDEF012, 4'hD),
                                36'h0FFFFFFFF, 4'hF));
    endtask : t_lanes

    // writes and reads alternating on consecutive edges, then two reads in a row, no turnaround
    task automatic t_b2b();
        wr(18'h11, 36'h111111111, 4'h0);
        idle(3);
        wr(18'h10, 36'h0A0A0A0A0, 4'h0);
        rd(18'h11);
        wr(18'h12, 36'h0C0C0C0C0, 4'h0);
        rd(18'h10);
        wr(18'h11, 36'h222222222, 4'h0);
        idle(2);
        rd(18'h12);
        rd(18'h11);
        idle(3);
        expect_beat(2'h2, 36'h0);
        expect_beat(2'h2, 36'h0);
        expect_beat(2'h1, 36'h111111111);
        expect_beat(2'h2, 36'h0);
        expect_beat(2'h1, 36'h0A0A0A0A0);
        expect_beat(2'h2, 36'h0);
        expect_beat(2'h1, 36'h0C0C0C0C0);
        expect_beat(2'h1, 36'h222222222);
    endtask : t_b2b

    // qualifier stretches a write and a read; output enable gates the drivers
    task automatic t_freeze();
        wr(18'h40, 36'h4F4F4F4F4, 4'h0);
        u_sram_ctrl_model.hold_on();
        repeat (3) @(posedge core_clk);
        u_sram_ctrl_model.hold_off();
        idle(3);
        rd(18'h40);
        idle(2);
        u_sram_ctrl_model.hold_on();
        repeat (2) @(posedge core_clk);
        #1 check(36'(dq_oe), 36'h1);
        @(posedge core_clk) output_enable_n <= 1'b1;
        #1 check(36'(dq_oe), 36'h0);
        @(posedge core_clk) output_enable_n <= 1'b0;
        #1 check(dq_out, 36'h4F4F4F4F4);
        check(36'(dq_oe), 36'h1);
        u_sram_ctrl_model.hold_off();
        idle(3);
        expect_beat(2'h2, 36'h0);
        expect_beat(2'h1, 36'h4F4F4F4F4);
    endtask : t_freeze

    // each false select, then sleep, leaves the stored word alone
    task automatic t_ignore();
        wr(18'h30, 36'h303030303, 4'h0);
        idle(3);
        for (int i = 0; i < 3; i++) u_sram_ctrl_model.issue(2'h0, 1'b0, 3'h2 ^ (3'h1 << i),
            4'h0, 1'b0, 18'h30, 36'hBADBADBAD);
        idle(3);
        @(posedge core_clk) sleep_request <= 1'b1;
        idle(4);
        u_sram_ctrl_model.issue(2'h0, 1'b0, 3'h2, 4'h0, 1'b0, 18'h30, 36'hBADBADBAD);
        idle(2);
        @(posedge core_clk) sleep_request <= 1'b0;
        idle(4);
        rd(18'h30);
        idle(3);
        expect_beat(2'h2, 36'h0);
        expect_beat(2'h1, 36'h303030303);
    endtask : t_ignore

    // four-beat bursts in both orders, read back one address at a time
    task automatic t_burst();
        logic [17:0] a;
        for (int o = 0; o < 2; o++) begin
            @(posedge core_clk) burst_order_linear <= o[0];
            idle(4);
            wr(18'h21, 36'h5A5A00000, 4'h0);
            for (int k = 1; k < 4; k++) u_sram_ctrl_model.issue(2'h2, 1'b0, 3'h2, 4'h0,
                1'b1, 18'h21, 36'h5A5A00000 + 36'(k));
            for (int k = 0; k < 4; k++) begin
                a = o[0] ? {16'h0008, 2'h1 + 2'(k)} : 18'h21 ^ 18'(k);
                rd(a);
            end
            idle(3);
            repeat (4) expect_beat(2'h2, 36'h0);
            for (int k = 0; k < 4; k++) expect_beat(2'h1, 36'h5A5A00000 + 36'(k));
        end
    endtask : t_burst

    // six writes in a row wrap the write command queue, then read back
    task automatic t_fifo();
        for (int k = 0; k < 6; k++) wr(18'(k), 36'(k + 9), 4'h0);
        for (int k = 0; k < 6; k++) rd(18'(k));
        idle(3);
        repeat (6) expect_beat(2'h2, 36'h0);
        for (int k = 0; k < 6; k++) expect_beat(2'h1, 36'(k + 9));
    endtask : t_fifo

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // =========================================================
    // main sequence
    initial begin
        {n_fail, checks_done, cycles} = '0;
        {nrst, output_enable_n, burst_order_linear, sleep_request} = 4'h0;
        repeat (4) @(posedge core_clk);
        #1 check(dq_out, 36'h0);
        check(36'(dq_oe), 36'h0);
        @(posedge core_clk) nrst <= 1'b1;
        repeat (6) @(posedge core_clk);
        check(36'(u_sram_port.DATA_W), 36'h24);
        check(36'(u_sram_port.ADDR_W), 36'h12);
        t_lanes();
        t_b2b();
        t_freeze();
        t_ignore();
        t_burst();
        t_fifo();
        end_of_test();
    end
endmodule : pipelined_burst_sram_port_tb
